// ==== t16_consts.svh ====
`ifndef T16_CONSTS_SVH
`define T16_CONSTS_SVH

// ----------------------------------------------------------------
// Byte locations on the 8-bit register port
// ----------------------------------------------------------------
`define T16_ADDR_CNT_L 3'h0
`define T16_ADDR_CNT_H 3'h1
`define T16_ADDR_CMPA_L 3'h2
`define T16_ADDR_CMPA_H 3'h3
`define T16_ADDR_CMPB_L 3'h4
`define T16_ADDR_CMPB_H 3'h5
`define T16_ADDR_CAP_L 3'h6
`define T16_ADDR_CAP_H 3'h7

// ----------------------------------------------------------------
// Flag and mask bit positions
// ----------------------------------------------------------------
`define T16_BIT_OVF 0
`define T16_BIT_CMPA 1
`define T16_BIT_CMPB 2
`define T16_BIT_CAP 3

// ----------------------------------------------------------------
// Fixed top values and counter limits
// ----------------------------------------------------------------
`define T16_TOP_8BIT 16'h00FF
`define T16_TOP_9BIT 16'h01FF
`define T16_TOP_10BIT 16'h03FF
`define T16_COUNT_FLOOR 16'h0000
`define T16_COUNT_MAX 16'hFFFF

// ----------------------------------------------------------------
// Prescaler tap masks (divide by 8, 64, 256, 1024)
// ----------------------------------------------------------------
`define T16_DIV8_MASK 10'h007
`define T16_DIV64_MASK 10'h03F
`define T16_DIV256_MASK 10'h0FF
`define T16_DIV1024_MASK 10'h3FF

// ----------------------------------------------------------------
// Capture noise filter length in samples
// ----------------------------------------------------------------
`define T16_FILTER_LEN 4

`endif

// ==== t16_pkg.sv ====
package t16_pkg;

  // Timer tick source, in the order of the select code
  typedef enum logic [2:0] {
    T16_CLK_OFF,
    T16_CLK_DIV1,
    T16_CLK_DIV8,
    T16_CLK_DIV64,
    T16_CLK_DIV256,
    T16_CLK_DIV1024,
    T16_CLK_EXT_FALL,
    T16_CLK_EXT_RISE
  } t16_clk_sel_t;

  // Source of the counter's top value
  typedef enum logic [2:0] {
    T16_TOP_MAX,
    T16_TOP_FIX8,
    T16_TOP_FIX9,
    T16_TOP_FIX10,
    T16_TOP_CMPA,
    T16_TOP_CAP
  } t16_top_sel_t;

endpackage

// ==== t16_noise_filter.sv ====
`timescale 1ns/10ps

module t16_noise_filter #(
  parameter int LEN = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control
  input wire logic enable,
  // Data
  input wire logic level_in,
  output logic level_out
);

  logic [LEN-1:0] history;

  // ----------------------------------------------------------------
  // Sample history
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      history <= '0;
    end else begin
      history <= {history[LEN-2:0], level_in};
    end
  end

  // ----------------------------------------------------------------
  // Output follows only after LEN equal samples when enabled
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      level_out <= 1'b0;
    end else if (!enable) begin
      level_out <= level_in;
    end else if (&history) begin
      level_out <= 1'b1;
    end else if (~|history) begin
      level_out <= 1'b0;
    end
  end

endmodule

// ==== t16_core.sv ====
// Overview of operation
// - Four flags: overflow, compare A, compare B, capture
// - Counter, compares, capture are 16-bit byte-accessed
// - Each request visible as flag, masked individually
// - Tick from clock, prescaler tap, or pin
// - Double buffered compares (held to the wrap in PWM mode) matched against counter on each tick without a counter write
// - Compare match sets that channel's flag
// - Capture edge latches counter into capture register
// - Optional noise filter on capture input
// - Top is fixed, compare A, or capture
// - Compare A as PWM top drives no output
// - Counter at floor when value becomes zero
// - Counter at maximum when value becomes FFFF
// - One shared high-byte holding register
// - Low-byte write loads held high byte too
// - Counter and capture low-byte reads copy high byte into holder
// - Compare reads bypass the holding register
// - Counter high location accesses the holder
// - Processor counter write beats clear and count
`timescale 1ns/10ps
`include "t16_consts.svh"

module t16_core
  import t16_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Byte register port
  input wire logic [2:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Control bits
  input wire logic timer_power_off_bit,
  input wire logic prescaler_reset,
  input wire t16_clk_sel_t clk_sel,
  input wire t16_top_sel_t top_sel,
  input wire logic pwm_mode,
  input wire logic capture_from_comparator,
  input wire logic capture_rising,
  input wire logic noise_cancel_en,
  // Flags, masks and requests
  input wire logic [3:0] timer_mask_reg,
  input wire logic [3:0] flag_clear,
  output logic [3:0] timer_flag_reg,
  output logic [3:0] irq_req,
  // Pins
  input wire logic ext_count_pin,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  output logic wave_out_a,
  output logic wave_out_b,
  // Counter status
  output logic [15:0] count_value_reg,
  output logic count_floor,
  output logic count_at_max
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] high_hold;
  logic [15:0] cmpa_buf;
  logic [15:0] cmpb_buf;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value_reg;
  logic [15:0] next_count;
  logic [15:0] top_value;
  logic [9:0] prescale;
  logic [1:0] ext_sync;
  logic ext_prev;
  logic [1:0] icp_sync;
  logic [1:0] aco_sync;
  logic cap_level;
  logic cap_prev;
  logic timer_tick;
  logic at_top;
  logic wrap;
  logic match_a;
  logic match_b;
  logic cap_event;
  logic wr_cnt;
  logic wr_cmpa;
  logic wr_cmpb;
  logic wr_cap;
  logic [3:0] set_flags;
  logic [3:0] next_flags;

  // ----------------------------------------------------------------
  // Free running prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prescale <= 10'h000;
    end else if (prescaler_reset) begin
      prescale <= 10'h000;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // External count pin: two-stage sync then edge memory
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ext_sync <= 2'h0;
      ext_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], ext_count_pin};
      ext_prev <= ext_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Tick select; no source or power-off holds the counter
  // ----------------------------------------------------------------
  always_comb begin
    case (clk_sel)
      T16_CLK_OFF: timer_tick = 1'b0;
      T16_CLK_DIV1: timer_tick = 1'b1;
      T16_CLK_DIV8:
        timer_tick = (prescale & `T16_DIV8_MASK) == `T16_DIV8_MASK;
      T16_CLK_DIV64:
        timer_tick = (prescale & `T16_DIV64_MASK) == `T16_DIV64_MASK;
      T16_CLK_DIV256:
        timer_tick = (prescale & `T16_DIV256_MASK) == `T16_DIV256_MASK;
      T16_CLK_DIV1024:
        timer_tick = prescale == `T16_DIV1024_MASK;
      T16_CLK_EXT_FALL: timer_tick = ext_prev & ~ext_sync[1];
      T16_CLK_EXT_RISE: timer_tick = ~ext_prev & ext_sync[1];
      default: timer_tick = 1'b0;
    endcase
    if (timer_power_off_bit) begin
      timer_tick = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Low-byte write strobes of the 16-bit registers
  // ----------------------------------------------------------------
  assign wr_cnt = cpu_wr && cpu_addr == `T16_ADDR_CNT_L;
  assign wr_cmpa = cpu_wr && cpu_addr == `T16_ADDR_CMPA_L;
  assign wr_cmpb = cpu_wr && cpu_addr == `T16_ADDR_CMPB_L;
  assign wr_cap = cpu_wr && cpu_addr == `T16_ADDR_CAP_L;

  // ----------------------------------------------------------------
  // Top value selection
  // ----------------------------------------------------------------
  always_comb begin
    case (top_sel)
      T16_TOP_MAX: top_value = `T16_COUNT_MAX;
      T16_TOP_FIX8: top_value = `T16_TOP_8BIT;
      T16_TOP_FIX9: top_value = `T16_TOP_9BIT;
      T16_TOP_FIX10: top_value = `T16_TOP_10BIT;
      T16_TOP_CMPA: top_value = compare_value_a;
      T16_TOP_CAP: top_value = capture_value_reg;
      default: top_value = `T16_COUNT_MAX;
    endcase
  end

  assign at_top = count_value_reg == top_value;
  assign wrap = timer_tick && at_top && !wr_cnt;
  assign match_a = timer_tick && !wr_cnt &&
                   count_value_reg == compare_value_a;
  assign match_b = timer_tick && !wr_cnt &&
                   count_value_reg == compare_value_b;

  // ----------------------------------------------------------------
  // Counter next value: processor write first, then count or wrap
  // ----------------------------------------------------------------
  always_comb begin
    if (wr_cnt) begin
      next_count = {high_hold, cpu_wdata};
    end else if (timer_tick && at_top) begin
      next_count = `T16_COUNT_FLOOR;
    end else if (timer_tick) begin
      next_count = count_value_reg + 16'h0001;
    end else begin
      next_count = count_value_reg;
    end
  end

  // ----------------------------------------------------------------
  // Counter and its floor and maximum indications
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_value_reg <= `T16_COUNT_FLOOR;
      count_floor <= 1'b1;
      count_at_max <= 1'b0;
    end else begin
      count_value_reg <= next_count;
      count_floor <= next_count == `T16_COUNT_FLOOR;
      count_at_max <= next_count == `T16_COUNT_MAX;
    end
  end

  // ----------------------------------------------------------------
  // Compare buffers written by the processor
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cmpa_buf <= 16'h0000;
      cmpb_buf <= 16'h0000;
    end else begin
      if (wr_cmpa) begin
        cmpa_buf <= {high_hold, cpu_wdata};
      end
      if (wr_cmpb) begin
        cmpb_buf <= {high_hold, cpu_wdata};
      end
    end
  end

  // ----------------------------------------------------------------
  // Active compares: in PWM mode they load only at the wrap
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      compare_value_a <= 16'h0000;
      compare_value_b <= 16'h0000;
    end else if (!pwm_mode || wrap) begin
      compare_value_a <= cmpa_buf;
      compare_value_b <= cmpb_buf;
    end
  end

  // ----------------------------------------------------------------
  // Capture input sync, optional filter and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      icp_sync <= 2'h0;
      aco_sync <= 2'h0;
      cap_prev <= 1'b0;
    end else begin
      icp_sync <= {icp_sync[0], capture_input_pin};
      aco_sync <= {aco_sync[0], comparator_out};
      cap_prev <= cap_level;
    end
  end

  t16_noise_filter #(
    .LEN(`T16_FILTER_LEN)
  ) u_filter (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(noise_cancel_en),
    .level_in(capture_from_comparator ? aco_sync[1] : icp_sync[1]),
    .level_out(cap_level)
  );

  // Capture is off while the capture register defines the top
  assign cap_event = (top_sel != T16_TOP_CAP) &&
                     (capture_rising ? (cap_level & ~cap_prev)
                                     : (~cap_level & cap_prev));

  // ----------------------------------------------------------------
  // Capture register: event latches counter, processor may load it
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_value_reg <= 16'h0000;
    end else if (wr_cap) begin
      capture_value_reg <= {high_hold, cpu_wdata};
    end else if (cap_event) begin
      capture_value_reg <= count_value_reg;
    end
  end

  // ----------------------------------------------------------------
  // Shared high-byte holding register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      high_hold <= 8'h00;
    end else if (cpu_wr) begin
      case (cpu_addr)
        `T16_ADDR_CNT_H: high_hold <= cpu_wdata;
        `T16_ADDR_CMPA_H: high_hold <= cpu_wdata;
        `T16_ADDR_CMPB_H: high_hold <= cpu_wdata;
        `T16_ADDR_CAP_H: high_hold <= cpu_wdata;
        default: high_hold <= high_hold;
      endcase
    end else if (cpu_rd) begin
      case (cpu_addr)
        `T16_ADDR_CNT_L: high_hold <= count_value_reg[15:8];
        `T16_ADDR_CAP_L: high_hold <= capture_value_reg[15:8];
        default: high_hold <= high_hold;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, registered; a write in the same cycle wins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd && !cpu_wr) begin
      case (cpu_addr)
        `T16_ADDR_CNT_L: cpu_rdata <= count_value_reg[7:0];
        `T16_ADDR_CNT_H: cpu_rdata <= high_hold;
        `T16_ADDR_CMPA_L: cpu_rdata <= cmpa_buf[7:0];
        `T16_ADDR_CMPA_H: cpu_rdata <= cmpa_buf[15:8];
        `T16_ADDR_CMPB_L: cpu_rdata <= cmpb_buf[7:0];
        `T16_ADDR_CMPB_H: cpu_rdata <= cmpb_buf[15:8];
        `T16_ADDR_CAP_L: cpu_rdata <= capture_value_reg[7:0];
        `T16_ADDR_CAP_H: cpu_rdata <= high_hold;
        default: cpu_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flag set and clear; a set in the clear cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    set_flags = 4'h0;
    set_flags[`T16_BIT_OVF] = wrap;
    set_flags[`T16_BIT_CMPA] = match_a;
    set_flags[`T16_BIT_CMPB] = match_b;
    set_flags[`T16_BIT_CAP] = cap_event;
    next_flags = (timer_flag_reg & ~flag_clear) | set_flags;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_flag_reg <= 4'h0;
      irq_req <= 4'h0;
    end else begin
      timer_flag_reg <= next_flags;
      irq_req <= next_flags & timer_mask_reg;
    end
  end

  // ----------------------------------------------------------------
  // Waveform outputs: PWM set at floor, clear at match (A held low while it sets top); else toggle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
    end else begin
      if (pwm_mode && top_sel == T16_TOP_CMPA) begin
        wave_out_a <= 1'b0;
      end else if (pwm_mode && match_a) begin
        wave_out_a <= 1'b0;
      end else if (pwm_mode && wrap) begin
        wave_out_a <= 1'b1;
      end else if (!pwm_mode && match_a) begin
        wave_out_a <= ~wave_out_a;
      end
      if (pwm_mode && match_b) begin
        wave_out_b <= 1'b0;
      end else if (pwm_mode && wrap) begin
        wave_out_b <= 1'b1;
      end else if (!pwm_mode && match_b) begin
        wave_out_b <= ~wave_out_b;
      end
    end
  end

endmodule

// ==== t16_core_asserts.sv ====
`timescale 1ns/10ps
`include "t16_consts.svh"

module t16_core_asserts
  import t16_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [2:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  // Control
  input wire logic timer_power_off_bit,
  input wire t16_clk_sel_t clk_sel,
  input wire t16_top_sel_t top_sel,
  input wire logic pwm_mode,
  input wire logic [3:0] timer_mask_reg,
  input wire logic [3:0] flag_clear,
  // Status
  input wire logic [3:0] timer_flag_reg,
  input wire logic [3:0] irq_req,
  input wire logic wave_out_a,
  input wire logic [15:0] count_value_reg,
  input wire logic count_floor
);
  logic cnt_wr;
  logic run1;
  logic stop;

  // Counter write, full-rate free run, and stopped tick
  assign cnt_wr = cpu_wr && cpu_addr == `T16_ADDR_CNT_L;
  assign run1 = clk_sel == T16_CLK_DIV1 && !timer_power_off_bit &&
    top_sel == T16_TOP_MAX && !cnt_wr;
  assign stop = timer_power_off_bit || clk_sel == T16_CLK_OFF;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  chk_floor_flag:
    assert property (count_floor == (count_value_reg == `T16_COUNT_FLOOR))
    else $error("Floor flag does not follow the counter");
  chk_irq_gate:
    assert property (irq_req == (timer_flag_reg & $past(timer_mask_reg)))
    else $error("Request is not flag gated by mask");
  chk_cnt_write:
    assert property (cnt_wr |=> count_value_reg[7:0] == $past(cpu_wdata))
    else $error("Counter low byte write lost");
  chk_read_low:
    assert property (cpu_rd && !cpu_wr && cpu_addr == `T16_ADDR_CNT_L
      |=> cpu_rdata == $past(count_value_reg[7:0]))
    else $error("Counter low byte read wrong");
  chk_rdata_stands:
    assert property (!cpu_rd || cpu_wr |=> $stable(cpu_rdata))
    else $error("Read data changed without a read");
  chk_stop_holds:
    assert property (stop && $past(stop) && !cnt_wr
      |=> $stable(count_value_reg))
    else $error("Counter moved with no tick");
  chk_full_rate:
    assert property ($past(run1) && run1
      |=> count_value_reg - $past(count_value_reg) == 16'h0001)
    else $error("Counter did not advance by one");
  chk_ovf_wrap:
    assert property ($past(run1) && run1 && count_value_reg == 16'hFFFF
      |=> timer_flag_reg[`T16_BIT_OVF])
    else $error("Overflow flag missing at wrap");
  chk_flag_sticky:
    assert property ((~timer_flag_reg & $past(timer_flag_reg) &
      ~$past(flag_clear)) == 4'h0)
    else $error("Flag dropped without a clear");
  chk_wave_a_off:
    assert property ($past(pwm_mode && top_sel == T16_TOP_CMPA)
      |-> !wave_out_a)
    else $error("Compare A output driven while it sets top");
endmodule

bind t16_core t16_core_asserts chk (.ref_clk, .rstn, .cpu_addr, .cpu_wr,
  .cpu_rd, .cpu_wdata, .cpu_rdata, .timer_power_off_bit, .clk_sel,
  .top_sel, .pwm_mode, .timer_mask_reg, .flag_clear, .timer_flag_reg,
  .irq_req, .wave_out_a, .count_value_reg, .count_floor);

// ==== t16_cpu_model.sv ====
`timescale 1ns/10ps

module t16_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Byte register port
  output logic [2:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata
);
  // Idle bus at time zero
  initial begin
    cpu_addr = 3'h0;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end

  // One byte access, held until the taking edge
  task automatic xfer(input logic wr, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wr <= wr;
    cpu_rd <= !wr;
    cpu_wdata <= d;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    cpu_wdata <= ~d;
    #1 q = cpu_rdata;
  endtask

  // Sixteen-bit write, high byte first
  task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, lo + 3'h1, v[15:8], q);
    xfer(1'b1, lo, v[7:0], q);
  endtask

  // Sixteen-bit read, low byte first
  task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
    xfer(1'b0, lo, 8'h00, v[7:0]);
    xfer(1'b0, lo + 3'h1, 8'h00, v[15:8]);
  endtask
endmodule

// ==== timer16_byte_access_core_test.sv ====
`timescale 1ns/10ps
`include "t16_consts.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  mismatches++; $display("unexpected at %0t: got %h want %h", \
  $time, (a), (b)); end end

module timer16_byte_access_core_test
  import t16_pkg::*;
;
  logic ref_clk = 1'b0, rstn = 1'b0;
  logic [2:0] cpu_addr;
  logic cpu_wr, cpu_rd, pwm_mode, capture_from_comparator, capture_rising;
  logic [7:0] cpu_wdata, cpu_rdata;
  logic timer_power_off_bit, prescaler_reset, noise_cancel_en;
  logic ext_count_pin, capture_input_pin, comparator_out;
  logic wave_out_a, wave_out_b, count_floor, count_at_max;
  logic [3:0] timer_mask_reg, flag_clear, timer_flag_reg, irq_req;
  logic [15:0] count_value_reg, v;
  t16_clk_sel_t clk_sel;
  t16_top_sel_t top_sel;
  t16_top_sel_t tsel [6];
  logic [15:0] tval [6];
  int mismatches = 0, checks_done = 0;

  t16_core dut (.ref_clk, .rstn, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata, .timer_power_off_bit, .prescaler_reset, .clk_sel, .top_sel,
    .pwm_mode, .capture_from_comparator, .capture_rising, .noise_cancel_en,
    .timer_mask_reg, .flag_clear, .timer_flag_reg, .irq_req, .ext_count_pin,
    .capture_input_pin, .comparator_out, .wave_out_a, .wave_out_b,
    .count_value_reg, .count_floor, .count_at_max);
  t16_cpu_model cpu (.ref_clk, .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata,
    .cpu_rdata);

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic pulse_clear;
    @(posedge ref_clk) flag_clear <= 4'hF;
    @(posedge ref_clk) flag_clear <= 4'h0;
    step(1);
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    while (timer_flag_reg[b] !== 1'b1 && n < 5000) begin
      step(1);
      n++;
    end
    if (n == 5000) begin
      mismatches++;
      $display("unexpected at %0t: flag %0d never set", $time, b);
    end
  endtask

  // Hang guard
  initial begin
    #1000000;
    mismatches++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    timer_power_off_bit = 1'b1;
    prescaler_reset = 1'b0;
    clk_sel = T16_CLK_DIV1;
    top_sel = T16_TOP_MAX;
    {pwm_mode, capture_from_comparator, ext_count_pin} = 3'h0;
    {capture_rising, noise_cancel_en, comparator_out} = 3'h7;
    capture_input_pin = 1'b0;
    timer_mask_reg = 4'hF;
    flag_clear = 4'h0;
    tsel = '{T16_TOP_MAX, T16_TOP_FIX8, T16_TOP_FIX9, T16_TOP_FIX10,
      T16_TOP_CMPA, T16_TOP_CAP};
    tval = '{16'hFFFF, `T16_TOP_8BIT, `T16_TOP_9BIT, `T16_TOP_10BIT,
      16'h0040, 16'h0BEF};
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    step(20);
    `CHK(count_floor, 1'b1)
    `CHK(count_value_reg, 16'h0000)
    @(posedge ref_clk) clk_sel <= T16_CLK_OFF;
    timer_power_off_bit <= 1'b0;
    // Shared holder across counter and compare registers
    cpu.wr16(`T16_ADDR_CNT_L, 16'h01FF);
    `CHK(count_value_reg, 16'h01FF)
    cpu.wr16(`T16_ADDR_CMPA_L, 16'h1234);
    cpu.xfer(1'b0, `T16_ADDR_CNT_L, 8'h00, v[7:0]);
    cpu.rd16(`T16_ADDR_CMPA_L, v);
    `CHK(v, 16'h1234)
    cpu.xfer(1'b0, `T16_ADDR_CNT_H, 8'h00, v[7:0]);
    `CHK(v[7:0], 8'h01)
    cpu.xfer(1'b1, `T16_ADDR_CMPB_H, 8'hAB, v[7:0]);
    cpu.xfer(1'b1, `T16_ADDR_CNT_L, 8'h00, v[7:0]);
    `CHK(count_value_reg, 16'hAB00)
    cpu.rd16(`T16_ADDR_CNT_L, v);
    `CHK(v, 16'hAB00)
    // Compare channels in toggle mode
    cpu.wr16(`T16_ADDR_CMPA_L, 16'h0010);
    cpu.wr16(`T16_ADDR_CMPB_L, 16'h0020);
    cpu.wr16(`T16_ADDR_CNT_L, 16'h0000);
    pulse_clear;
    @(posedge ref_clk) clk_sel <= T16_CLK_DIV1;
    wait_flag(`T16_BIT_CMPA);
    `CHK(timer_flag_reg[`T16_BIT_CMPB], 1'b0)
    step(2);
    `CHK(wave_out_a, 1'b1)
    `CHK(irq_req[`T16_BIT_CMPA], 1'b1)
    wait_flag(`T16_BIT_CMPB);
    step(2);
    `CHK(wave_out_b, 1'b1)
    // Filtered spike, then pin and comparator captures
    @(posedge ref_clk) clk_sel <= T16_CLK_OFF;
    pulse_clear;
    @(posedge ref_clk) capture_input_pin <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk) capture_input_pin <= 1'b0;
    step(12);
    `CHK(timer_flag_reg[`T16_BIT_CAP], 1'b0)
    for (int i = 0; i < 2; i++) begin
      cpu.wr16(`T16_ADDR_CNT_L, {15'h05F7, i[0]});
      pulse_clear;
      @(posedge ref_clk) capture_from_comparator <= i[0];
      capture_rising <= !i[0];
      @(posedge ref_clk);
      if (i == 0) capture_input_pin <= 1'b1;
      else comparator_out <= 1'b0;
      wait_flag(`T16_BIT_CAP);
      cpu.rd16(`T16_ADDR_CAP_L, v);
      `CHK(v, {15'h05F7, i[0]})
    end
    // Every top source wraps to zero with overflow
    cpu.wr16(`T16_ADDR_CMPA_L, 16'h0040);
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk) clk_sel <= T16_CLK_OFF;
      top_sel <= tsel[i];
      cpu.wr16(`T16_ADDR_CNT_L, tval[i] - 16'h0002);
      pulse_clear;
      @(posedge ref_clk) clk_sel <= T16_CLK_DIV1;
      wait_flag(`T16_BIT_OVF);
      `CHK(count_value_reg, 16'h0000)
      `CHK(irq_req[`T16_BIT_OVF], 1'b1)
    end
    // Mask gates requests, clear drops flags
    @(posedge ref_clk) clk_sel <= T16_CLK_OFF;
    timer_mask_reg <= 4'h0;
    step(2);
    `CHK(irq_req, 4'h0)
    `CHK(timer_flag_reg[`T16_BIT_OVF], 1'b1)
    pulse_clear;
    `CHK(timer_flag_reg, 4'h0)
    cpu.wr16(`T16_ADDR_CNT_L, 16'hFFFF);
    `CHK({count_at_max, count_floor}, 2'h2)
    // External edges; the falling run starts with the pin high
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk) clk_sel <= T16_CLK_OFF;
      ext_count_pin <= m[0];
      cpu.wr16(`T16_ADDR_CNT_L, 16'h0000);
      @(posedge ref_clk);
      clk_sel <= m[0] ? T16_CLK_EXT_FALL : T16_CLK_EXT_RISE;
      repeat (3) begin
        @(posedge ref_clk) ext_count_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        ext_count_pin <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      step(5);
      `CHK(count_value_reg, 16'h0003)
    end
    // Divide-by-eight tap after a prescaler restart
    @(posedge ref_clk) prescaler_reset <= 1'b1;
    clk_sel <= T16_CLK_DIV8;
    cpu.wr16(`T16_ADDR_CNT_L, 16'h0000);
    @(posedge ref_clk) prescaler_reset <= 1'b0;
    step(36);
    `CHK(count_value_reg, 16'h0004)
    // Compare A as PWM top forces its raised output low at once
    @(posedge ref_clk) clk_sel <= T16_CLK_DIV1;
    wait_flag(`T16_BIT_CMPA);
    `CHK(wave_out_a, 1'b1)
    @(posedge ref_clk) pwm_mode <= 1'b1;
    top_sel <= T16_TOP_CMPA;
    step(2);
    `CHK(wave_out_a, 1'b0)
    report_and_stop;
  end
endmodule
